// ===== design/dtd_pkg.sv
// What this block does
// (RULE1) table entry address is the device number times four, a two-place left shift
// (RULE2) table starts at octal 14; lower locations never hold entries
// (RULE3) table ends at octal 1777, so at most 253 four-word entries
// (RULE4) lowest device number is 3; numbers 0, 1 and 2 are refused; the channel service path still grants them but skips the table read
// (RULE5) entry is four words: three absolute addresses, then an interrupt flag word
// (RULE6) word one points at the channel program; multiplexed channels advance it
// (RULE7) word two holds the start of the controller's interrupt routine
// (RULE8) word three holds the address of the controller's data area
// (RULE9) flag word four is never touched by the dispatch path
// (RULE10) start instruction commands the controller to run its channel program
// (RULE11) four direct instructions each move one word with the stack top word
// (RULE12) competing channel service requests are settled by fixed hardware priority
// (RULE13) start instruction loads word one with the channel program start address
// (RULE14) device number is an eight-bit field so every entry fits the table
package dtd_pkg;

	// table geometry, octal 14 and octal 1777
	localparam logic [15:0] TABLE_BASE = 16'h000C;
	localparam logic [15:0] TABLE_TOP  = 16'h03FF;
	localparam logic [7:0]  DEV_MIN    = 8'h03;
	localparam int          ENTRY_WORDS = 4;

	// word offsets inside one entry
	localparam logic [1:0] W_PROG  = 2'h0;
	localparam logic [1:0] W_ROUT  = 2'h1;
	localparam logic [1:0] W_DATA  = 2'h2;
	localparam logic [1:0] W_FLAG  = 2'h3;

	// instruction codes on the dispatch port
	localparam logic [2:0] OP_START = 3'h0;
	localparam logic [2:0] OP_READ  = 3'h1;
	localparam logic [2:0] OP_WRITE = 3'h2;
	localparam logic [2:0] OP_TEST  = 3'h3;
	localparam logic [2:0] OP_CTRL  = 3'h4;

	// direct operation codes toward the controller
	localparam logic [1:0] DIR_READ  = 2'h0;
	localparam logic [1:0] DIR_WRITE = 2'h1;
	localparam logic [1:0] DIR_TEST  = 2'h2;
	localparam logic [1:0] DIR_CTRL  = 2'h3;

	// channel service slots, slot 0 is highest priority
	localparam int          SVC_SLOTS = 8;
	localparam logic [15:0] PROG_STEP = 16'h0001;

	typedef enum logic [2:0] {
		S_IDLE     = 3'h0,
		S_START_WR = 3'h1,
		S_DIR_WAIT = 3'h2,
		S_INT_ROUT = 3'h3,
		S_INT_DATA = 3'h4,
		S_SVC_RD   = 3'h5,
		S_SVC_WR   = 3'h6
	} dtd_state_t;

	typedef struct packed {
		dtd_state_t  st;
		logic [7:0]  dev;
		logic        mux;
		logic        io_ready;
		logic        io_done;
		logic        io_err;
		logic [15:0] io_result;
		logic        mem_req;
		logic        mem_we;
		logic [15:0] mem_addr;
		logic [15:0] mem_wdata;
		logic [7:0]  ctl_dev;
		logic        ctl_start;
		logic        ctl_direct;
		logic [1:0]  ctl_direct_op;
		logic [15:0] ctl_wdata;
		logic [7:0]  svc_grant;
		logic        svc_valid;
		logic [15:0] svc_word;
		logic        int_ready;
		logic        int_done;
		logic        int_err;
		logic [15:0] int_routine_start;
		logic [15:0] int_data_area_pointer;
	} dtd_regs_t;

endpackage

// ===== design/dtd_prio_arb.sv
`timescale 1ns/100ps
module dtd_prio_arb #(
	parameter int N = 8
) (
	// requests, index 0 wins
	input  wire logic [N-1:0]         req,
	// result
	output logic                      any,
	output logic [$clog2(N)-1:0]      idx
);

	// scan from the top down so the lowest index is the one left standing
	always_comb begin
		any = 1'b0;
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i]) begin
				any = 1'b1;
				idx = ($clog2(N))'(i); // [RULE12]
			end
		end
	end

endmodule

// ===== design/dtd_dispatch.sv
`timescale 1ns/100ps
module dtd_dispatch (
	// clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst,
	// instruction port from the processor
	input  wire logic                     io_valid,
	input  wire logic [2:0]               io_op,
	input  wire logic [7:0]               io_dev,
	input  wire logic [15:0]              io_stack_top_word,
	input  wire logic [15:0]              io_prog_start,
	output logic                          io_ready,
	output logic                          io_done,
	output logic                          io_err,
	output logic [15:0]                   io_result,
	// memory port toward the entry table
	output logic                          mem_req,
	output logic                          mem_we,
	output logic [15:0]                   mem_addr,
	output logic [15:0]                   mem_wdata,
	input  wire logic [15:0]              mem_rdata,
	input  wire logic                     mem_ack,
	// controller command port
	output logic [7:0]                    ctl_dev,
	output logic                          ctl_start,
	output logic                          ctl_direct,
	output logic [1:0]                    ctl_direct_op,
	output logic [15:0]                   ctl_wdata,
	input  wire logic [15:0]              ctl_rdata,
	input  wire logic                     ctl_ack,
	// channel program service
	input  wire logic [dtd_pkg::SVC_SLOTS-1:0]      svc_req,
	input  wire logic [dtd_pkg::SVC_SLOTS-1:0][7:0] svc_dev,
	input  wire logic [dtd_pkg::SVC_SLOTS-1:0]      svc_mux,
	output logic [dtd_pkg::SVC_SLOTS-1:0] svc_grant,
	output logic                          svc_valid,
	output logic [15:0]                   svc_word,
	// interrupt entry lookup
	input  wire logic                     int_req,
	input  wire logic [7:0]               int_dev,
	output logic                          int_ready,
	output logic                          int_done,
	output logic                          int_err,
	output logic [15:0]                   int_routine_start,
	output logic [15:0]                   int_data_area_pointer
);
	import dtd_pkg::*;

	dtd_regs_t r_ff;
	dtd_regs_t nxt_r;
	logic      svc_any;
	logic [2:0] svc_idx;
	logic      io_take;
	logic      int_take;
	logic      svc_take;

	// entry address: device number shifted two places, word offset in the low bits
	function automatic logic [15:0] entry_addr(input logic [7:0] d, input logic [1:0] w);
		return {6'h00, d, w}; // [RULE1] [RULE3] [RULE5] [RULE14]
	endfunction

	dtd_prio_arb #(
		.N   (SVC_SLOTS)
	) u_arb (
		.req (svc_req),
		.any (svc_any),
		.idx (svc_idx)
	);

	// instruction beats interrupt lookup, which beats channel service
	assign io_take  = (r_ff.st == S_IDLE) && io_valid && r_ff.io_ready;
	assign int_take = (r_ff.st == S_IDLE) && !io_take && int_req && r_ff.int_ready;
	assign svc_take = (r_ff.st == S_IDLE) && !io_take && !int_take && svc_any;

	// next state; pulses fall back to zero every cycle
	always_comb begin
		nxt_r = r_ff;
		nxt_r.io_done    = 1'b0;
		nxt_r.io_err     = 1'b0;
		nxt_r.ctl_start  = 1'b0;
		nxt_r.ctl_direct = 1'b0;
		nxt_r.svc_grant  = '0;
		nxt_r.svc_valid  = 1'b0;
		nxt_r.int_done   = 1'b0;
		nxt_r.int_err    = 1'b0;
		unique case (r_ff.st)
			S_IDLE: begin
				if (io_take) begin
					nxt_r.dev = io_dev;
					if (io_dev < DEV_MIN || io_op > OP_CTRL) begin
						nxt_r.io_err = 1'b1; // [RULE4] [RULE2]
					end else if (io_op == OP_START) begin
						// program pointer is written before the controller is told to go
						nxt_r.mem_req   = 1'b1;
						nxt_r.mem_we    = 1'b1;
						nxt_r.mem_addr  = entry_addr(io_dev, W_PROG); // [RULE13] [RULE6]
						nxt_r.mem_wdata = io_prog_start;
						nxt_r.io_ready  = 1'b0;
						nxt_r.int_ready = 1'b0;
						nxt_r.st        = S_START_WR;
					end else begin
						// direct path never touches the table
						nxt_r.ctl_dev    = io_dev;
						nxt_r.ctl_direct = 1'b1; // [RULE11]
						nxt_r.ctl_wdata  = io_stack_top_word;
						nxt_r.io_ready   = 1'b0;
						nxt_r.int_ready  = 1'b0;
						nxt_r.st         = S_DIR_WAIT;
						unique case (io_op)
							OP_READ:  nxt_r.ctl_direct_op = DIR_READ;
							OP_WRITE: nxt_r.ctl_direct_op = DIR_WRITE;
							OP_TEST:  nxt_r.ctl_direct_op = DIR_TEST;
							default:  nxt_r.ctl_direct_op = DIR_CTRL;
						endcase
					end
				end else if (int_take) begin
					nxt_r.dev = int_dev;
					if (int_dev < DEV_MIN) begin
						nxt_r.int_err = 1'b1; // [RULE4]
					end else begin
						nxt_r.mem_req   = 1'b1;
						nxt_r.mem_we    = 1'b0;
						nxt_r.mem_addr  = entry_addr(int_dev, W_ROUT); // [RULE7]
						nxt_r.io_ready  = 1'b0;
						nxt_r.int_ready = 1'b0;
						nxt_r.st        = S_INT_ROUT;
					end
				end else if (svc_take) begin
					// device numbers below the minimum are the channel side's fault; grant them but skip the table read
					nxt_r.svc_grant[svc_idx] = 1'b1; // [RULE12]
					nxt_r.dev = svc_dev[svc_idx];
					nxt_r.mux = svc_mux[svc_idx];
					if (svc_dev[svc_idx] >= DEV_MIN) begin
						nxt_r.mem_req   = 1'b1;
						nxt_r.mem_we    = 1'b0;
						nxt_r.mem_addr  = entry_addr(svc_dev[svc_idx], W_PROG); // [RULE6]
						nxt_r.io_ready  = 1'b0;
						nxt_r.int_ready = 1'b0;
						nxt_r.st        = S_SVC_RD;
					end
				end
			end
			S_START_WR: begin
				if (mem_ack) begin
					nxt_r.mem_req   = 1'b0;
					nxt_r.mem_we    = 1'b0;
					nxt_r.ctl_dev   = r_ff.dev;
					nxt_r.ctl_start = 1'b1; // [RULE10]
					nxt_r.io_done   = 1'b1;
					nxt_r.io_ready  = 1'b1;
					nxt_r.int_ready = 1'b1;
					nxt_r.st        = S_IDLE;
				end
			end
			S_DIR_WAIT: begin
				if (ctl_ack) begin
					nxt_r.io_result = ctl_rdata; // [RULE11]
					nxt_r.io_done   = 1'b1;
					nxt_r.io_ready  = 1'b1;
					nxt_r.int_ready = 1'b1;
					nxt_r.st        = S_IDLE;
				end
			end
			S_INT_ROUT: begin
				if (mem_ack) begin
					nxt_r.int_routine_start = mem_rdata; // [RULE7]
					nxt_r.mem_addr = entry_addr(r_ff.dev, W_DATA); // [RULE8]
					nxt_r.st       = S_INT_DATA;
				end
			end
			S_INT_DATA: begin
				if (mem_ack) begin
					nxt_r.int_data_area_pointer = mem_rdata; // [RULE8]
					nxt_r.mem_req   = 1'b0;
					nxt_r.int_done  = 1'b1;
					nxt_r.io_ready  = 1'b1;
					nxt_r.int_ready = 1'b1;
					nxt_r.st        = S_IDLE;
				end
			end
			S_SVC_RD: begin
				if (mem_ack) begin
					nxt_r.svc_word  = mem_rdata;
					nxt_r.svc_valid = 1'b1;
					if (r_ff.mux) begin
						// write back the advanced pointer; selector channels keep their own
						nxt_r.mem_we    = 1'b1;
						nxt_r.mem_wdata = mem_rdata + PROG_STEP; // [RULE6]
						nxt_r.st        = S_SVC_WR;
					end else begin
						nxt_r.mem_req   = 1'b0;
						nxt_r.io_ready  = 1'b1;
						nxt_r.int_ready = 1'b1;
						nxt_r.st        = S_IDLE;
					end
				end
			end
			S_SVC_WR: begin
				if (mem_ack) begin
					nxt_r.mem_req   = 1'b0;
					nxt_r.mem_we    = 1'b0;
					nxt_r.io_ready  = 1'b1;
					nxt_r.int_ready = 1'b1;
					nxt_r.st        = S_IDLE;
				end
			end
			default: begin
				// unused code, recover to idle
				nxt_r.mem_req   = 1'b0;
				nxt_r.mem_we    = 1'b0;
				nxt_r.io_ready  = 1'b1;
				nxt_r.int_ready = 1'b1;
				nxt_r.st        = S_IDLE;
			end
		endcase
	end

	// whole state in one register; ready lines come up high out of reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r_ff           <= '0;
			r_ff.io_ready  <= 1'b1;
			r_ff.int_ready <= 1'b1;
		end else begin
			r_ff <= nxt_r;
		end
	end

	// outputs straight from the state register
	assign io_ready              = r_ff.io_ready;
	assign io_done               = r_ff.io_done;
	assign io_err                = r_ff.io_err;
	assign io_result             = r_ff.io_result;
	assign mem_req               = r_ff.mem_req;
	assign mem_we                = r_ff.mem_we;
	assign mem_addr              = r_ff.mem_addr;
	assign mem_wdata             = r_ff.mem_wdata;
	assign ctl_dev               = r_ff.ctl_dev;
	assign ctl_start             = r_ff.ctl_start;
	assign ctl_direct            = r_ff.ctl_direct;
	assign ctl_direct_op         = r_ff.ctl_direct_op;
	assign ctl_wdata             = r_ff.ctl_wdata;
	assign svc_grant             = r_ff.svc_grant;
	assign svc_valid             = r_ff.svc_valid;
	assign svc_word              = r_ff.svc_word;
	assign int_ready             = r_ff.int_ready;
	assign int_done              = r_ff.int_done;
	assign int_err               = r_ff.int_err;
	assign int_routine_start     = r_ff.int_routine_start;
	assign int_data_area_pointer = r_ff.int_data_area_pointer;

	// checks on what this block drives
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	start_entry_a: assert property ( // [RULE1] [RULE13]
		io_take && io_op == OP_START && io_dev >= DEV_MIN
		|=> mem_req && mem_we && mem_addr == {6'h00, $past(io_dev), 2'h0}
		&& mem_wdata == $past(io_prog_start))
		else $error("start did not write word one of the entry");
	base_floor_a: assert property (mem_req |-> mem_addr >= TABLE_BASE) // [RULE2]
		else $error("table access below base");
	top_ceiling_a: assert property (mem_req |-> mem_addr <= TABLE_TOP) // [RULE3]
		else $error("table access above top");
	flag_untouched_a: assert property (mem_req |-> mem_addr[1:0] != W_FLAG) // [RULE9]
		else $error("flag word was accessed");
	low_dev_reject_a: assert property ( // [RULE4]
		io_take && io_dev < DEV_MIN
		|=> io_err && !mem_req && !ctl_direct && !ctl_start)
		else $error("low device number not refused");
	int_low_reject_a: assert property ( // [RULE4]
		int_take && int_dev < DEV_MIN
		|=> int_err && !mem_req && !int_done)
		else $error("low device lookup not refused");
	start_cmd_a: assert property ( // [RULE10]
		r_ff.st == S_START_WR && mem_ack
		|=> ctl_start && io_done && ctl_dev == $past(r_ff.dev) ##1 !ctl_start)
		else $error("controller start not issued once");
	direct_word_a: assert property ( // [RULE11]
		r_ff.st == S_DIR_WAIT && ctl_ack
		|=> io_done && io_result == $past(ctl_rdata) && !mem_req)
		else $error("direct word not returned");
	direct_nomem_a: assert property (ctl_direct |-> !mem_req [*2]) // [RULE11]
		else $error("direct instruction touched memory");
	mux_advance_a: assert property ( // [RULE6]
		r_ff.st == S_SVC_RD && mem_ack && r_ff.mux
		|=> mem_we && mem_wdata == $past(mem_rdata) + PROG_STEP)
		else $error("program pointer not advanced");
	prio_grant_a: assert property ( // [RULE12]
		svc_take
		|=> svc_grant == ($past(svc_req) & (~$past(svc_req) + 8'h01)))
		else $error("service grant not lowest slot");
	routine_word_a: assert property ( // [RULE7]
		r_ff.st == S_INT_ROUT && mem_ack
		|=> int_routine_start == $past(mem_rdata) && mem_addr[1:0] == W_DATA)
		else $error("routine start not taken from word two");
	data_area_a: assert property ( // [RULE8]
		r_ff.st == S_INT_DATA && mem_ack
		|=> int_done && int_data_area_pointer == $past(mem_rdata))
		else $error("data area not taken from word three");

	start_seen_c: cover property (ctl_start);
	direct_seen_c: cover property (ctl_direct ##[1:20] io_done);
	mux_seen_c: cover property (r_ff.st == S_SVC_WR && mem_ack);
	int_seen_c: cover property (int_done);
	refuse_seen_c: cover property (io_err || int_err);

endmodule

// ===== sim/dtd_far_model.sv
`timescale 1ns/100ps
// entry table memory and the controllers behind the dispatch block
module dtd_far_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// answer delay in cycles, zero is prompt
	input  wire logic [3:0]  lat,
	// memory port
	input  wire logic        mem_req,
	input  wire logic        mem_we,
	input  wire logic [15:0] mem_addr,
	input  wire logic [15:0] mem_wdata,
	output logic [15:0]      mem_rdata,
	output logic             mem_ack,
	// controller port
	input  wire logic        ctl_direct,
	input  wire logic [15:0] ctl_wdata,
	output logic [15:0]      ctl_rdata,
	output logic             ctl_ack
);
	logic [15:0] mem [0:1023];
	logic [3:0]  mcnt;
	logic [3:0]  ccnt;
	logic        cbusy;
	logic [15:0] cw;

	// four-word entries filled with a known pattern
	initial for (int i = 0; i < 1024; i++) mem[i] = 16'(i) ^ 16'hA5A5;

	// one ack pulse per access; data line toggles when not answering
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			mcnt <= 4'h0;
			mem_ack <= 1'b0;
			mem_rdata <= 16'h0;
		end else if (mem_req && !mem_ack && mcnt >= lat) begin
			mem_ack <= 1'b1;
			mcnt <= 4'h0;
			if (mem_we) mem[mem_addr[9:0]] <= mem_wdata;
			mem_rdata <= mem[mem_addr[9:0]];
		end else begin
			mem_ack <= 1'b0;
			mcnt <= (mem_req && !mem_ack) ? mcnt + 4'h1 : 4'h0;
			mem_rdata <= ~mem_rdata;
		end
	end

	// each direct command answers with exactly one word
	always @(posedge clk or posedge rst) begin
		if (rst) begin
			cbusy <= 1'b0;
			ctl_ack <= 1'b0;
			ctl_rdata <= 16'h0;
			ccnt <= 4'h0;
			cw <= 16'h0;
		end else if (ctl_direct) begin
			cbusy <= 1'b1;
			cw <= ctl_wdata;
			ccnt <= 4'h0;
			ctl_ack <= 1'b0;
		end else if (cbusy && ccnt >= lat) begin
			ctl_ack <= 1'b1;
			cbusy <= 1'b0;
			ctl_rdata <= cw ^ 16'h3C3C;
		end else begin
			ctl_ack <= 1'b0;
			ccnt <= ccnt + 4'h1;
			ctl_rdata <= ~ctl_rdata;
		end
	end
endmodule

// ===== sim/device_table_io_dispatch_bench.sv
`timescale 1ns/100ps
module device_table_io_dispatch_bench;
	import dtd_pkg::*;
	logic                          clk, rst, io_valid, io_ready, io_done, io_err;
	logic [2:0]                    io_op, op;
	logic [7:0]                    io_dev, dev, int_dev, st_dev, eg;
	logic [15:0]                   io_stack_top_word, io_prog_start, io_result, stk, prg;
	logic                          mem_req, mem_we, mem_ack, ctl_start, ctl_direct, ctl_ack;
	logic [15:0]                   mem_addr, mem_wdata, mem_rdata, ctl_wdata, ctl_rdata;
	logic [7:0]                    ctl_dev;
	logic [1:0]                    ctl_direct_op, d_op;
	logic [SVC_SLOTS-1:0]          svc_req, svc_mux, svc_grant;
	logic [SVC_SLOTS-1:0][7:0]     svc_dev;
	logic                          svc_valid, int_req, int_ready, int_done, int_err;
	logic [15:0]                   svc_word, int_routine_start, int_data_area_pointer;
	logic [15:0]                   d_w, wr_addr;
	logic [15:0]                   shadow [0:1023];
	logic [3:0]                    lat;
	int                            mismatches, tests_run, flag_hits, range_bad, starts, s0, n, k, w;

	// free-running 100 MHz clock
	always #5 clk = ~clk;

	dtd_dispatch dut (.clk(clk), .rst(rst), .io_valid(io_valid), .io_op(io_op),
		.io_dev(io_dev), .io_stack_top_word(io_stack_top_word),
		.io_prog_start(io_prog_start), .io_ready(io_ready), .io_done(io_done),
		.io_err(io_err), .io_result(io_result), .mem_req(mem_req), .mem_we(mem_we),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.mem_ack(mem_ack), .ctl_dev(ctl_dev), .ctl_start(ctl_start),
		.ctl_direct(ctl_direct), .ctl_direct_op(ctl_direct_op), .ctl_wdata(ctl_wdata),
		.ctl_rdata(ctl_rdata), .ctl_ack(ctl_ack), .svc_req(svc_req), .svc_dev(svc_dev),
		.svc_mux(svc_mux), .svc_grant(svc_grant), .svc_valid(svc_valid),
		.svc_word(svc_word), .int_req(int_req), .int_dev(int_dev), .int_ready(int_ready),
		.int_done(int_done), .int_err(int_err), .int_routine_start(int_routine_start),
		.int_data_area_pointer(int_data_area_pointer));

	dtd_far_model far (.clk(clk), .rst(rst), .lat(lat), .mem_req(mem_req),
		.mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .ctl_direct(ctl_direct),
		.ctl_wdata(ctl_wdata), .ctl_rdata(ctl_rdata), .ctl_ack(ctl_ack));

	// watch the ports for commands, table writes and stray accesses
	always @(posedge clk) begin
		if (ctl_start) starts++;
		if (ctl_start) st_dev = ctl_dev;
		if (ctl_direct) d_op = ctl_direct_op;
		if (ctl_direct) d_w = ctl_wdata;
		if (mem_req && mem_ack && mem_we) wr_addr = mem_addr;
		if (mem_req && mem_addr[1:0] == W_FLAG) flag_hits++;
		if (mem_req && (mem_addr < TABLE_BASE || mem_addr > TABLE_TOP)) range_bad++;
	end

	task check(input logic [15:0] seen, input logic [15:0] exp);
		tests_run++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task give_verdict;
		$display("comparisons %0d mismatches %0d", tests_run, mismatches);
		if (mismatches == 0 && tests_run > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	// inputs move a little after the rising edge
	task step;
		@(posedge clk);
		#1;
	endtask

	task run_out;
		mismatches++;
		$display("[ERR] %0t wait ran out", $time);
		give_verdict;
	endtask

	// one instruction, held until the take edge, then wait for its answer
	task do_io(input logic [2:0] o, input logic [7:0] d, input logic [15:0] s, p);
		io_op = o;
		io_dev = d;
		io_stack_top_word = s;
		io_prog_start = p;
		io_valid = 1'b1;
		step;
		io_valid = 1'b0;
		for (n = 0; !(io_done || io_err) && n < 300; n++) step;
		if (n == 300) run_out;
	endtask

	task do_int(input logic [7:0] d);
		int_dev = d;
		int_req = 1'b1;
		step;
		int_req = 1'b0;
		for (n = 0; !(int_done || int_err) && n < 300; n++) step;
		if (n == 300) run_out;
	endtask

	initial begin
		{clk, io_valid, io_op, io_dev, io_stack_top_word, io_prog_start} = '0;
		{int_req, int_dev, svc_req, svc_dev, svc_mux, lat} = '0;
		{mismatches, tests_run, flag_hits, range_bad, starts} = '0;
		rst = 1'b1;
		for (int i = 0; i < 1024; i++) shadow[i] = 16'(i) ^ 16'hA5A5;
		void'($urandom(79));
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		check(16'({io_ready, int_ready, io_done, mem_req, ctl_start, svc_valid}), 16'h0030);
		$display("reset test done");
		// start ops, lowest and highest device first, back to back
		for (int i = 0; i < 12; i++) begin
			dev = (i == 0) ? 8'h03 : (i == 1) ? 8'hFF : 8'(3 + $urandom % 253);
			prg = 16'($urandom);
			lat = 4'($urandom % 6);
			do_io(OP_START, dev, 16'h0, prg);
			shadow[{dev, 2'b00}] = prg;
			check(16'(io_err), 16'h0);
			check(16'(ctl_start), 16'h1);
			check(16'(ctl_dev), 16'(dev));
			// the port watcher only sees the start pulse at the next edge
			step;
			check(wr_addr, {6'h0, dev, 2'b00});
			check(far.mem[{dev, 2'b00}], prg);
			check(16'(st_dev), 16'(dev));
			check(16'(starts), 16'(i + 1));
		end
		$display("start test done");
		// every direct code, one word each way, no program launched
		s0 = starts;
		for (int i = 0; i < 16; i++) begin
			op = 3'(1 + i % 4);
			stk = 16'($urandom);
			lat = 4'($urandom % 6);
			do_io(op, 8'(3 + $urandom % 253), stk, 16'h0);
			check(16'(d_op), 16'(op - 3'h1));
			check(d_w, stk);
			check(io_result, stk ^ 16'h3C3C);
		end
		check(16'(starts), 16'(s0));
		$display("direct test done");
		// unassigned devices and illegal codes are refused
		for (int i = 0; i < 6; i++) begin
			do_io(i < 3 ? OP_START : 3'(i + 2), i < 3 ? 8'(i) : 8'h10, 16'h0, 16'h1234);
			check(16'(io_err), 16'h1);
		end
		check(16'(starts), 16'(s0));
		$display("refusal test done");
		// interrupt lookups read words two and three only
		for (int i = 0; i < 10; i++) begin
			dev = (i == 0) ? 8'h03 : 8'(3 + $urandom % 253);
			lat = 4'($urandom % 6);
			do_int(dev);
			check(int_routine_start, shadow[{dev, 2'b01}]);
			check(int_data_area_pointer, shadow[{dev, 2'b10}]);
		end
		do_int(8'h01);
		check(16'(int_err), 16'h1);
		$display("interrupt test done");
		// competing service requests, one slot unassigned
		for (int s = 0; s < SVC_SLOTS; s++) svc_dev[s] = 8'(10 + s * 30 + $urandom % 20);
		svc_dev[7] = 8'h01;
		svc_mux = 8'($urandom);
		for (int r = 0; r < 2; r++) begin
			svc_req = (r == 0) ? 8'hFF : 8'($urandom) | 8'h01;
			lat = 4'($urandom % 6);
			for (n = 0; svc_req != 0 && n < 600; n++) begin
				step;
				if (svc_grant != 0) begin
					eg = svc_req & (~svc_req + 8'h01);
					check(16'(svc_grant), 16'(eg));
					for (int b = 0; b < 8; b++) if (svc_grant[b]) k = b;
					svc_req = svc_req & ~svc_grant;
					for (w = 0; svc_dev[k] > 8'h02 && !svc_valid && w < 50; w++) step;
					if (w == 50) run_out;
					if (svc_dev[k] > 8'h02) check(svc_word, shadow[{svc_dev[k], 2'b00}]);
					if (svc_dev[k] > 8'h02 && svc_mux[k]) shadow[{svc_dev[k], 2'b00}]++;
				end
			end
			if (n == 600) run_out;
		end
		for (n = 0; mem_req && n < 50; n++) step;
		if (n == 50) run_out;
		step;
		for (int s = 0; s < 7; s++) begin
			check(far.mem[{svc_dev[s], 2'b00}], shadow[{svc_dev[s], 2'b00}]);
		end
		check(16'(flag_hits), 16'h0);
		check(16'(range_bad), 16'h0);
		$display("service test done");
		give_verdict;
	end
endmodule
